// ### rtl/dsp_opdec_map.svh
// Field positions, codes, register offsets and reset values of the slice opcode decoder
`ifndef DSP_OPDEC_MAP_SVH
`define DSP_OPDEC_MAP_SVH

// ****************************************************************
// Instruction word fields
// ****************************************************************
`define OPW_MSB 21
`define XY_MSB 3
`define XY_LSB 0
`define Z_MSB 6
`define Z_LSB 4
`define W_MSB 8
`define W_LSB 7
`define ALU_MSB 12
`define ALU_LSB 9
`define CRY_MSB 16
`define CRY_LSB 13
`define PRE_MSB 21
`define PRE_LSB 17
`define CIN_BIT 11
`define CIN_ALU_BIT 2
`define Z_SHIFT 17

// ****************************************************************
// Field codes
// ****************************************************************
`define XY_ZERO 4'h0
`define XY_P 4'h1
`define XY_AB 4'h2
`define XY_MUL 4'h3
`define XY_C 4'h4
`define XY_PC 4'h5
`define XY_ABC 4'h6
`define Z_ZERO 3'h0
`define Z_CASC 3'h1
`define Z_P 3'h2
`define Z_C 3'h3
`define Z_CASC_SHR 3'h4
`define Z_P_SHR 3'h5
`define W_ZERO 2'h0
`define W_P 2'h1
`define W_RND 2'h2
`define W_C 2'h3
`define ALU_ADD 4'h0
`define ALU_ZSUB 4'h3
`define ALU_LAST 4'hD
`define CRY_ZERO 4'h0
`define CRY_ONE 4'h1
`define CRY_EXT 4'h2
`define CRY_LAST 4'h9
`define PRE_ZERO 5'h00
`define PRE_MUL 5'h01
`define PRE_LAST 5'h15

// ****************************************************************
// Preset operation codes
// ****************************************************************
`define PS_C_MUL 3'h0
`define PS_CASC_MUL 3'h1
`define PS_P_MUL 3'h2
`define PS_MUL 3'h3
`define PS_C_AB 3'h4
`define PS_C_SUB_AB 3'h5
`define PS_C 3'h6
`define PS_CUSTOM 3'h7

// ****************************************************************
// Register map
// ****************************************************************
`define REG_CFG 4'h0
`define REG_STATUS 4'h4
`define REG_WORD 4'h8
`define CFG_PS_MSB 2
`define CFG_PS_LSB 0
`define CFG_ASEL 4
`define CFG_BSEL 5
`define ST_ILLEGAL 0
`define ST_CUSTOM 1
`define ST_CIN_EXT 2
`define CFG_PS_RST 3'h7
`define DATA_ZERO 32'h0000_0000

`endif

// ### rtl/dsp_opdec_pkg.sv
// Field types of the slice opcode decoder
`include "dsp_opdec_map.svh"
`default_nettype none
package dsp_opdec_pkg;
  typedef logic [`OPW_MSB:0] op_word_t;
  typedef logic [`XY_MSB-`XY_LSB:0] xy_sel_t;
  typedef logic [`Z_MSB-`Z_LSB:0] z_sel_t;
  typedef logic [`W_MSB-`W_LSB:0] w_sel_t;
  typedef logic [`ALU_MSB-`ALU_LSB:0] alu_func_t;
  typedef logic [`CRY_MSB-`CRY_LSB:0] carry_sel_t;
  typedef logic [`PRE_MSB-`PRE_LSB:0] premul_t;
  typedef enum logic [2:0] {
    PS_C_MUL = `PS_C_MUL,
    PS_CASC_MUL = `PS_CASC_MUL,
    PS_P_MUL = `PS_P_MUL,
    PS_MUL = `PS_MUL,
    PS_C_AB = `PS_C_AB,
    PS_C_SUB_AB = `PS_C_SUB_AB,
    PS_C = `PS_C,
    PS_CUSTOM = `PS_CUSTOM
  } preset_t;
endpackage
`default_nettype wire

// ### rtl/dsp_slice_opcode_decoder.sv
// Top of the slice opcode decoder with its Wishbone register file
//
// Operation
// - op[3:0] selects X/Y source: zero, P, A:B, A*B, C, P+C, A:B+C.
// - Concatenated operand puts A in the upper bits, B below.
// - op[6:4] selects Z source: zero, cascade_in, P, C, or shifted forms.
// - Shifted Z sources are arithmetic right shifts by seventeen.
// - op[8:7] selects W source: zero, P, rounding_constant, or C.
// - op[12:9] selects one of the arithmetic or logic ALU functions.
// - op[16:13] selects carry source, including constant zero or one.
// - External carry source inserts carry_in_ext into the word at bit 11.
// - Carry codes also cover rounding, wide add/sub/acc and product rounding.
// - op[21:17] selects one of 22 pre-adder/multiplier functions.
// - Preset equations cover common cases; custom uses the word fields.
// - A and B operands each come from their first or second stage.
`include "dsp_opdec_map.svh"
`default_nettype none
module dsp_slice_opcode_decoder #(
  parameter int AW = 30,
  parameter int BW = 18,
  parameter int PW = 48
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire dsp_opdec_pkg::op_word_t instr_word,
  input wire logic carry_in_ext,
  input wire logic [AW-1:0] a1,
  input wire logic [AW-1:0] a2,
  input wire logic [BW-1:0] b1,
  input wire logic [BW-1:0] b2,
  input wire logic [PW-1:0] cascade_in,
  input wire logic [PW-1:0] p_fb,
  output dsp_opdec_pkg::xy_sel_t xy_sel,
  output dsp_opdec_pkg::z_sel_t z_sel,
  output dsp_opdec_pkg::w_sel_t w_sel,
  output dsp_opdec_pkg::alu_func_t alu_func,
  output dsp_opdec_pkg::carry_sel_t carry_sel,
  output dsp_opdec_pkg::premul_t premul,
  output logic [AW-1:0] a_op,
  output logic [BW-1:0] b_op,
  output logic [AW+BW-1:0] ab_concat,
  output logic [PW-1:0] casc_shr,
  output logic [PW-1:0] p_shr,
  output logic op_illegal
);
  dsp_opdec_pkg::preset_t cfg_preset_r;
  logic cfg_asel_r;
  logic cfg_bsel_r;
  dsp_opdec_pkg::op_word_t eff_word;
  dsp_opdec_pkg::op_word_t eff_word_r;
  dsp_opdec_pkg::xy_sel_t dec_xy;
  dsp_opdec_pkg::z_sel_t dec_z;
  dsp_opdec_pkg::w_sel_t dec_w;
  dsp_opdec_pkg::alu_func_t dec_alu;
  dsp_opdec_pkg::carry_sel_t dec_carry;
  dsp_opdec_pkg::premul_t dec_pre;
  logic dec_illegal;
  logic [AW-1:0] fm_a;
  logic [BW-1:0] fm_b;
  logic [AW+BW-1:0] fm_ab;
  logic [PW-1:0] fm_casc_shr;
  logic [PW-1:0] fm_p_shr;
  logic wb_req;
  logic wb_wr;
  logic [31:0] rd_nxt;
  logic cfg_custom;

  // ****************************************************************
  // Decode and operand forming
  // ****************************************************************
  opcode_field_decoder u_dec (
    .op_word(instr_word),
    .carry_in_ext(carry_in_ext),
    .preset(cfg_preset_r),
    .eff_word(eff_word),
    .xy_sel(dec_xy),
    .z_sel(dec_z),
    .w_sel(dec_w),
    .alu_func(dec_alu),
    .carry_sel(dec_carry),
    .premul(dec_pre),
    .illegal(dec_illegal)
  );

  operand_former #(
    .AW(AW),
    .BW(BW),
    .PW(PW)
  ) u_form (
    .a1(a1),
    .a2(a2),
    .b1(b1),
    .b2(b2),
    .a_sel(cfg_asel_r),
    .b_sel(cfg_bsel_r),
    .cascade_in(cascade_in),
    .p_fb(p_fb),
    .a_op(fm_a),
    .b_op(fm_b),
    .ab_concat(fm_ab),
    .casc_shr(fm_casc_shr),
    .p_shr(fm_p_shr)
  );

  assign cfg_custom = (cfg_preset_r == dsp_opdec_pkg::PS_CUSTOM);

  // ****************************************************************
  // Registered slice controls
  // ****************************************************************
  // One register stage: the slice sees a new word at its next edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      xy_sel <= `XY_ZERO;
      z_sel <= `Z_ZERO;
      w_sel <= `W_ZERO;
      alu_func <= `ALU_ADD;
      carry_sel <= `CRY_ZERO;
      premul <= `PRE_ZERO;
      op_illegal <= 1'b0;
      eff_word_r <= '0;
    end else begin
      xy_sel <= dec_xy;
      z_sel <= dec_z;
      w_sel <= dec_w;
      alu_func <= dec_alu;
      carry_sel <= dec_carry;
      premul <= dec_pre;
      op_illegal <= dec_illegal;
      eff_word_r <= eff_word;
    end
  end

  // Operands registered too, so every output leaves a flip-flop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      a_op <= '0;
      b_op <= '0;
      ab_concat <= '0;
      casc_shr <= '0;
      p_shr <= '0;
    end else begin
      a_op <= fm_a;
      b_op <= fm_b;
      ab_concat <= fm_ab;
      casc_shr <= fm_casc_shr;
      p_shr <= fm_p_shr;
    end
  end

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // Only byte lane 0 carries configuration bits
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_preset_r <= dsp_opdec_pkg::preset_t'(`CFG_PS_RST);
      cfg_asel_r <= 1'b0;
      cfg_bsel_r <= 1'b0;
    end else if (wb_wr && (wb_adr_i == `REG_CFG) && wb_sel_i[0]) begin
      cfg_preset_r <= dsp_opdec_pkg::preset_t'(wb_dat_i[`CFG_PS_MSB:`CFG_PS_LSB]);
      cfg_asel_r <= wb_dat_i[`CFG_ASEL];
      cfg_bsel_r <= wb_dat_i[`CFG_BSEL];
    end
  end

  always_comb begin
    rd_nxt = `DATA_ZERO;
    unique case (wb_adr_i)
      `REG_CFG: begin
        rd_nxt[`CFG_PS_MSB:`CFG_PS_LSB] = cfg_preset_r;
        rd_nxt[`CFG_ASEL] = cfg_asel_r;
        rd_nxt[`CFG_BSEL] = cfg_bsel_r;
      end
      `REG_STATUS: begin
        rd_nxt[`ST_ILLEGAL] = op_illegal;
        rd_nxt[`ST_CUSTOM] = cfg_custom;
        rd_nxt[`ST_CIN_EXT] = (carry_sel == `CRY_EXT);
      end
      `REG_WORD: begin
        rd_nxt[`OPW_MSB:0] = eff_word_r;
      end
      default: begin
        rd_nxt = `DATA_ZERO;
      end
    endcase
  end

  // Unmapped addresses still ack, reading zero and ignoring writes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= `DATA_ZERO;
    end else if (wb_req && !wb_we_i) begin
      wb_dat_o <= rd_nxt;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_xy_custom_field: assert property (
    cfg_custom && !wb_wr |=> xy_sel == $past(instr_word[`XY_MSB:`XY_LSB])
  ) else $error("X/Y select does not follow the word");

  a_concat_order: assert property (
    1'b1 |=> ab_concat[AW+BW-1:BW] == a_op && ab_concat[BW-1:0] == b_op
  ) else $error("A:B concat order wrong");

  a_z_custom_field: assert property (
    cfg_custom && !wb_wr |=> z_sel == $past(instr_word[`Z_MSB:`Z_LSB])
  ) else $error("Z select does not follow the word");

  a_z_shift_amount: assert property (
    1'b1 |=> casc_shr == $past($signed(cascade_in) >>> `Z_SHIFT)
         && p_shr == $past($signed(p_fb) >>> `Z_SHIFT)
  ) else $error("Z downshift wrong");

  a_w_custom_field: assert property (
    cfg_custom && !wb_wr |=> w_sel == $past(instr_word[`W_MSB:`W_LSB])
  ) else $error("W select does not follow the word");

  a_alu_custom_field: assert property (
    cfg_custom && !wb_wr && instr_word[`CRY_MSB:`CRY_LSB] != `CRY_EXT
    |=> alu_func == $past(instr_word[`ALU_MSB:`ALU_LSB])
  ) else $error("ALU function does not follow the word");

  a_carry_custom_field: assert property (
    cfg_custom && !wb_wr |=> carry_sel == $past(instr_word[`CRY_MSB:`CRY_LSB])
  ) else $error("Carry select does not follow the word");

  a_cin_insert: assert property (
    cfg_custom && !wb_wr && instr_word[`CRY_MSB:`CRY_LSB] == `CRY_EXT
    |=> alu_func[`CIN_ALU_BIT] == $past(carry_in_ext)
  ) else $error("External carry not inserted at bit 11");

  a_premul_field: assert property (
    cfg_custom && !wb_wr |=> premul == $past(instr_word[`PRE_MSB:`PRE_LSB])
  ) else $error("Pre-adder function does not follow the word");

  a_preset_mac: assert property (
    cfg_preset_r == dsp_opdec_pkg::PS_C_MUL && !wb_wr
    |=> xy_sel == `XY_MUL && z_sel == `Z_C && alu_func == `ALU_ADD && premul == `PRE_MUL
  ) else $error("Preset C+A*B decoded wrong");

  a_preset_sub: assert property (
    cfg_preset_r == dsp_opdec_pkg::PS_C_SUB_AB && !wb_wr
    |=> xy_sel == `XY_AB && alu_func == `ALU_ZSUB
  ) else $error("Preset C-A:B decoded wrong");

  a_reg_stage_pick: assert property (
    !wb_wr |=> a_op == $past(cfg_asel_r ? a2 : a1) && b_op == $past(cfg_bsel_r ? b2 : b1)
  ) else $error("A/B stage choice wrong");

  a_wb_ack_pulse: assert property (
    wb_req |=> wb_ack_o ##1 !wb_ack_o
  ) else $error("Ack not a single-cycle answer");

  // Carry field is never rewritten, so its range is judged on the raw word
  a_illegal_flag: assert property (
    cfg_custom && !wb_wr && (instr_word[`XY_MSB:`XY_LSB] > `XY_ABC
    || instr_word[`Z_MSB:`Z_LSB] > `Z_P_SHR || instr_word[`CRY_MSB:`CRY_LSB] > `CRY_LAST
    || instr_word[`PRE_MSB:`PRE_LSB] > `PRE_LAST) |=> op_illegal
  ) else $error("Out-of-range field code not flagged");

  a_preset_fixed: assert property (
    !cfg_custom && !wb_wr |=> w_sel == `W_ZERO && carry_sel == `CRY_ZERO && !op_illegal
  ) else $error("Preset word carries a stray field");

  a_cfg_stage_write: assert property (
    wb_wr && wb_adr_i == `REG_CFG && wb_sel_i[0]
    |=> cfg_asel_r == $past(wb_dat_i[`CFG_ASEL]) && cfg_bsel_r == $past(wb_dat_i[`CFG_BSEL])
  ) else $error("Stage choice not taken from the write");

  c_custom_cin: cover property (
    cfg_custom && instr_word[`CRY_MSB:`CRY_LSB] == `CRY_EXT ##1 alu_func[`CIN_ALU_BIT]
  );
  c_preset_casc: cover property (cfg_preset_r == dsp_opdec_pkg::PS_CASC_MUL ##1 z_sel == `Z_CASC);
  c_illegal_word: cover property (op_illegal);
  c_cfg_write: cover property (wb_wr && wb_adr_i == `REG_CFG);
  c_stage_two: cover property (cfg_asel_r && cfg_bsel_r);
endmodule // dsp_slice_opcode_decoder
`default_nettype wire

// ### rtl/opcode_field_decoder.sv
// Combinational split of the instruction word into slice control fields
`include "dsp_opdec_map.svh"
`default_nettype none
module opcode_field_decoder (
  input wire dsp_opdec_pkg::op_word_t op_word,
  input wire logic carry_in_ext,
  input wire dsp_opdec_pkg::preset_t preset,
  output dsp_opdec_pkg::op_word_t eff_word,
  output dsp_opdec_pkg::xy_sel_t xy_sel,
  output dsp_opdec_pkg::z_sel_t z_sel,
  output dsp_opdec_pkg::w_sel_t w_sel,
  output dsp_opdec_pkg::alu_func_t alu_func,
  output dsp_opdec_pkg::carry_sel_t carry_sel,
  output dsp_opdec_pkg::premul_t premul,
  output logic illegal
);
  function automatic dsp_opdec_pkg::op_word_t pack(input dsp_opdec_pkg::xy_sel_t xy,
      input dsp_opdec_pkg::z_sel_t z, input dsp_opdec_pkg::alu_func_t alu,
      input dsp_opdec_pkg::premul_t pre);
    dsp_opdec_pkg::op_word_t w;
    w = '0;
    w[`XY_MSB:`XY_LSB] = xy;
    w[`Z_MSB:`Z_LSB] = z;
    w[`W_MSB:`W_LSB] = `W_ZERO;
    w[`ALU_MSB:`ALU_LSB] = alu;
    w[`CRY_MSB:`CRY_LSB] = `CRY_ZERO;
    w[`PRE_MSB:`PRE_LSB] = pre;
    return w;
  endfunction

  dsp_opdec_pkg::op_word_t preset_word;

  // ****************************************************************
  // Preset equations
  // ****************************************************************
  always_comb begin
    preset_word = '0;
    unique case (preset)
      dsp_opdec_pkg::PS_C_MUL: preset_word = pack(`XY_MUL, `Z_C, `ALU_ADD, `PRE_MUL);
      dsp_opdec_pkg::PS_CASC_MUL: preset_word = pack(`XY_MUL, `Z_CASC, `ALU_ADD, `PRE_MUL);
      dsp_opdec_pkg::PS_P_MUL: preset_word = pack(`XY_MUL, `Z_P, `ALU_ADD, `PRE_MUL);
      dsp_opdec_pkg::PS_MUL: preset_word = pack(`XY_MUL, `Z_ZERO, `ALU_ADD, `PRE_MUL);
      dsp_opdec_pkg::PS_C_AB: preset_word = pack(`XY_AB, `Z_C, `ALU_ADD, `PRE_ZERO);
      dsp_opdec_pkg::PS_C_SUB_AB: preset_word = pack(`XY_AB, `Z_C, `ALU_ZSUB, `PRE_ZERO);
      dsp_opdec_pkg::PS_C: preset_word = pack(`XY_ZERO, `Z_C, `ALU_ADD, `PRE_ZERO);
      dsp_opdec_pkg::PS_CUSTOM: preset_word = op_word;
    endcase
  end

  // ****************************************************************
  // Field split, carry insertion, range check
  // ****************************************************************
  always_comb begin
    eff_word = preset_word;
    if (preset_word[`CRY_MSB:`CRY_LSB] == `CRY_EXT) begin
      eff_word[`CIN_BIT] = carry_in_ext;
    end
  end

  assign xy_sel = eff_word[`XY_MSB:`XY_LSB];
  assign z_sel = eff_word[`Z_MSB:`Z_LSB];
  assign w_sel = eff_word[`W_MSB:`W_LSB];
  assign alu_func = eff_word[`ALU_MSB:`ALU_LSB];
  assign carry_sel = eff_word[`CRY_MSB:`CRY_LSB];
  assign premul = eff_word[`PRE_MSB:`PRE_LSB];
  // Codes past the last listed entry have no slice meaning
  assign illegal = (xy_sel > `XY_ABC) || (z_sel > `Z_P_SHR) || (alu_func > `ALU_LAST)
                   || (carry_sel > `CRY_LAST) || (premul > `PRE_LAST);
endmodule // opcode_field_decoder
`default_nettype wire

// ### rtl/operand_former.sv
// Register-stage choice, A:B concatenation and downshifted Z operands
`include "dsp_opdec_map.svh"
`default_nettype none
module operand_former #(
  parameter int AW = 30,
  parameter int BW = 18,
  parameter int PW = 48
) (
  input wire logic [AW-1:0] a1,
  input wire logic [AW-1:0] a2,
  input wire logic [BW-1:0] b1,
  input wire logic [BW-1:0] b2,
  input wire logic a_sel,
  input wire logic b_sel,
  input wire logic [PW-1:0] cascade_in,
  input wire logic [PW-1:0] p_fb,
  output logic [AW-1:0] a_op,
  output logic [BW-1:0] b_op,
  output logic [AW+BW-1:0] ab_concat,
  output logic [PW-1:0] casc_shr,
  output logic [PW-1:0] p_shr
);
  assign a_op = a_sel ? a2 : a1;
  assign b_op = b_sel ? b2 : b1;
  assign ab_concat = {a_op, b_op};
  // Arithmetic shift keeps the sign of wide accumulations
  assign casc_shr = $signed(cascade_in) >>> `Z_SHIFT;
  assign p_shr = $signed(p_fb) >>> `Z_SHIFT;
endmodule // operand_former
`default_nettype wire

// ### tb/dsp_slice_opcode_decoder_tb_top.sv
// Self-checking bench of the slice opcode decoder
`default_nettype none
module dsp_slice_opcode_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Stimulus and design
  // ****************************************************************
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [3:0] wb_adr = 4'h0, wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0000_0000, wb_dat_o, rd;
  logic wb_ack_o, cin_req = 1'b0, carry_in_ext, op_illegal;
  logic [21:0] word_req = 22'h000000, instr_word;
  logic [29:0] a1 = '0, a2 = '0, a_op;
  logic [17:0] b1 = '0, b2 = '0, b_op;
  logic [47:0] cascade_in = '0, p_fb = '0, ab_concat, casc_shr, p_shr;
  logic [3:0] xy_sel, alu_func, carry_sel;
  logic [2:0] z_sel;
  logic [1:0] w_sel;
  logic [4:0] premul;
  int seed = 22231;
  int fails = 0, tests_run = 0, cyc_cnt = 0;
  logic [22:0] fq[$];
  logic [191:0] oq[$];

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  instr_source src_u (.ref_clk(ref_clk), .rst_n(rst_n), .word_req(word_req),
    .cin_req(cin_req), .instr_word(instr_word), .carry_in_ext(carry_in_ext));

  dsp_slice_opcode_decoder dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .instr_word(instr_word),
    .carry_in_ext(carry_in_ext), .a1(a1), .a2(a2), .b1(b1), .b2(b2),
    .cascade_in(cascade_in), .p_fb(p_fb), .xy_sel(xy_sel), .z_sel(z_sel), .w_sel(w_sel),
    .alu_func(alu_func), .carry_sel(carry_sel), .premul(premul), .a_op(a_op), .b_op(b_op),
    .ab_concat(ab_concat), .casc_shr(casc_shr), .p_shr(p_shr), .op_illegal(op_illegal));

  // ****************************************************************
  // Model and helpers
  // ****************************************************************
  function automatic logic [22:0] exp_fields(input logic [21:0] w, input logic c, input int ps);
    logic [21:0] e;
    int ps_xy[7] = '{3, 3, 3, 3, 2, 2, 0};
    int ps_z[7] = '{3, 1, 2, 0, 3, 3, 3};
    e = w;
    if (ps != 7) begin
      e = '0;
      e[3:0] = 4'(ps_xy[ps]);
      e[6:4] = 3'(ps_z[ps]);
      e[12:9] = (ps == 5) ? 4'h3 : 4'h0;
      e[21:17] = (ps < 4) ? 5'h01 : 5'h00;
    end else if (w[16:13] == 4'h2) begin
      e[11] = c;
    end
    return {e, ps == 7 && (e[3:0] > 6 || e[6:4] > 5 || e[12:9] > 13 || e[16:13] > 9
      || e[21:17] > 21)};
  endfunction

  task automatic chk(input string nm, input logic [191:0] seen, input logic [191:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wb(input logic we, input logic [3:0] adr, input logic [3:0] sel,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= sel;
    wb_dat <= d;
    // Only the bench ceiling ends a missing answer
    do begin
      @(posedge ref_clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic set_cfg(input int ps, input logic as, input logic bs);
    wb(1'b1, 4'h0, 4'hF, {26'h0, bs, as, 1'b0, 3'(ps)}, rd);
  endtask

  // Mode 0 random words, 1 sweep of every field code, 2 external carry forced
  task automatic run(input int n, input int mode, input int ps, input logic as,
      input logic bs);
    logic [21:0] w;
    logic c;
    logic [29:0] x1, x2;
    logic [17:0] y1, y2;
    logic [47:0] pc, pp;
    for (int i = 0; i <= n; i++) begin
      @(posedge ref_clk);
      if (i < n) begin
        w = 22'($random(seed));
        c = 1'($random(seed));
        if (mode == 1) w = {i[4:0], i[3:0], i[3:0], i[1:0], i[2:0], i[3:0]};
        if (mode == 2) w[16:13] = 4'h2;
        x1 = 30'($random(seed));
        x2 = 30'($random(seed));
        y1 = 18'($random(seed));
        y2 = 18'($random(seed));
        pc = {16'($random(seed)), 32'($random(seed))};
        pp = {16'($random(seed)), 32'($random(seed))};
        word_req <= w;
        cin_req <= c;
        a1 <= x1;
        a2 <= x2;
        b1 <= y1;
        b2 <= y2;
        cascade_in <= pc;
        p_fb <= pp;
        fq.push_back(exp_fields(w, c, ps));
        oq.push_back({as ? x2 : x1, bs ? y2 : y1, as ? x2 : x1, bs ? y2 : y1,
          48'($signed(pc) >>> 17), 48'($signed(pp) >>> 17)});
      end
      #1;
      if (i > 0) begin
        chk("fields", {premul, carry_sel, alu_func, w_sel, z_sel, xy_sel, op_illegal},
          fq.pop_front());
        chk("operands", {a_op, b_op, ab_concat, casc_shr, p_shr},
          oq.pop_front());
      end
    end
    $display("test mode %0d preset %0d done", mode, ps);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Ceiling well above the roughly 600 cycles the sequence needs
  always @(posedge ref_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 6000) begin
      fails++;
      end_sim();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (16) @(posedge ref_clk);
    #1;
    chk("reset outputs", {premul, carry_sel, alu_func, w_sel, z_sel, xy_sel, op_illegal,
      a_op, ab_concat, casc_shr}, '0);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    wb(1'b0, 4'h0, 4'hF, 32'h0, rd);
    chk("cfg reset", rd, 32'h0000_0007);
    wb(1'b1, 4'hC, 4'hF, 32'hFFFF_FFFF, rd);
    wb(1'b0, 4'hC, 4'hF, 32'h0, rd);
    chk("unmapped", rd, 32'h0000_0000);
    wb(1'b1, 4'h0, 4'hE, 32'h0000_0030, rd);
    wb(1'b0, 4'h0, 4'hF, 32'h0, rd);
    chk("cfg lane off", rd, 32'h0000_0007);
    $display("test registers done");
    @(posedge ref_clk);
    word_req <= 22'h00400F;
    cin_req <= 1'b1;
    repeat (2) @(posedge ref_clk);
    wb(1'b0, 4'h4, 4'hF, 32'h0, rd);
    chk("status", rd, 32'h0000_0007);
    wb(1'b0, 4'h8, 4'hF, 32'h0, rd);
    chk("word", rd, 32'h0000_480F);
    run(32, 1, 7, 1'b0, 1'b0);
    for (int s = 0; s < 4; s++) begin
      set_cfg(7, s[0], s[1]);
      run(100, 0, 7, s[0], s[1]);
    end
    run(40, 2, 7, 1'b1, 1'b1);
    for (int ps = 0; ps < 7; ps++) begin
      set_cfg(ps, 1'b0, 1'b0);
      run(8, 0, ps, 1'b0, 1'b0);
    end
    end_sim();
  end
endmodule // dsp_slice_opcode_decoder_tb_top
`default_nettype wire

// ### tb/instr_source.sv
// Upstream logic model that drives the instruction word and external carry
`default_nettype none
module instr_source (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [21:0] word_req,
  input wire logic cin_req,
  output logic [21:0] instr_word,
  output logic carry_in_ext
);
  timeunit 1ns;
  timeprecision 1ps;
  logic toggle_r;
  // Carry line is junk unless the word picks it, so a stale value cannot pass
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      toggle_r <= 1'b0;
    end else begin
      toggle_r <= ~toggle_r;
    end
  end
  assign instr_word = word_req;
  assign carry_in_ext = (word_req[16:13] == 4'h2) ? cin_req : toggle_r;
endmodule // instr_source
`default_nettype wire
